// ### rtl/kpq_top.sv
// Key event queue read-out and key controller configuration behind a two-wire serial slave.
// Assumes key events arrive on the scan clock domain; SCL/SDA are asynchronous pins.
`timescale 1ns/10ps
`include "kpq_regs.svh"
module kpq_top #(
	parameter int DEPTH = `KPQ_QUEUE_DEPTH,
	parameter int TIMEOUT_CYCLES = `KPQ_TIMEOUT_MS * `KPQ_CLK_KHZ,
	parameter logic [6:0] DEV_ADDR = `KPQ_DEV_ADDR
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic int_n,
	input wire logic cc_pwm_en,
	input wire logic autosleep_req,
	output logic scan_active,
	output logic bus_timeout_en,
	input wire logic scan_clk,
	input wire logic scan_reset_n,
	input wire logic ev_valid,
	input wire logic [5:0] ev_key,
	input wire logic ev_release,
	input wire logic ev_repeat,
	output logic ev_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
	localparam logic [TW-1:0] TO_LIMIT = TW'(TIMEOUT_CYCLES);

	// ==========================================================
	// Scan domain: toggle handshake carries one event at a time
	// ==========================================================
	logic req_q, req_d;
	logic [7:0] hold_q, hold_d;
	logic ready_q, ready_d;
	logic ack_q, ack_s;

	kpq_sync #(.WIDTH(1)) ack_sync (.clk(scan_clk), .reset_n(scan_reset_n), .d(ack_q), .q(ack_s));

	always_comb begin
		req_d = req_q;
		hold_d = hold_q;
		if (ev_valid && ready_q) begin
			req_d = ~req_q;
			hold_d = {ev_repeat, ev_release, ev_key};
		end
		ready_d = (req_d == ack_s);
	end

	always_ff @(posedge scan_clk) begin
		if (!scan_reset_n) begin
			req_q <= 1'b0;
			hold_q <= 8'h00;
			ready_q <= 1'b0;
		end else begin
			req_q <= req_d;
			hold_q <= hold_d;
			ready_q <= ready_d;
		end
	end
	assign ev_ready = ready_q;

	// ==========================================================
	// Main domain: pin and request synchronisers
	// ==========================================================
	logic scl_s, sda_s, req_s;

	// Pins come out of reset at their idle high level, so no false bus edge follows reset
	kpq_sync #(.WIDTH(3), .INIT({1'b1, 1'b1, 1'b0})) pin_sync (.clk(clk), .reset_n(reset_n),
		.d({scl_i, sda_i, req_q}), .q({scl_s, sda_s, req_s}));

	// ==========================================================
	// Main domain state
	// ==========================================================
	logic [7:0] mem [DEPTH];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0] cnt_q, cnt_d;
	logic ovf_q, ovf_d, ack_d, int_n_q, int_n_d;
	logic [7:0] cfg_q, cfg_d;
	logic scan_q, scan_d, to_en_q, to_en_d;
	logic scl_p_q, sda_p_q;
	kpq_pkg::kpq_bus_state_type st_q, st_d;
	logic [3:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
	logic rw_q, rw_d, nack_q, nack_d, oe_q, oe_d;
	logic [TW-1:0] to_q, to_d;
	logic new_ev, press, accept, push, load, pop, is_event;
	logic [7:0] ent, rd_byte;
	logic more;

	always_comb begin
		ent = mem[rp_q];
		more = (cnt_q > (AW + 1)'(1));
		is_event = (ptr_q == `KPQ_OFS_EVENT);
		if (!is_event)
			rd_byte = (ptr_q == `KPQ_OFS_CONFIG) ? cfg_q : 8'h00;
		else if (ovf_q)
			rd_byte = {1'b0, 1'b1, `KPQ_KEY_ALL1};
		else if (cnt_q == '0)
			rd_byte = {1'b0, 1'b0, `KPQ_KEY_ALL1};
		else if (ent[`KPQ_ENT_RPT])
			rd_byte = {1'b0, more, `KPQ_KEY_REPEAT};
		else if (ent[5:0] >= `KPQ_KEY_REPEAT)
			rd_byte = {1'b1, ent[`KPQ_EV_REL], ent[5:0]};
		else
			rd_byte = {more, ent[`KPQ_EV_REL], ent[5:0]};
	end

	always_comb begin
		st_d = st_q;
		bit_d = bit_q;
		sh_d = sh_q;
		ptr_d = ptr_q;
		rw_d = rw_q;
		nack_d = nack_q;
		oe_d = oe_q;
		cfg_d = cfg_q;
		load = 1'b0;
		to_d = (to_en_q && st_q != kpq_pkg::KPQ_IDLE && !scl_s) ? to_q + TW'(1) : '0;
		if (scl_s && scl_p_q && sda_p_q && !sda_s) begin
			st_d = kpq_pkg::KPQ_ADDR;
			bit_d = 4'h0;
			oe_d = 1'b0;
		end else if ((scl_s && scl_p_q && !sda_p_q && sda_s) || to_q == TO_LIMIT) begin
			// A stuck clock line cannot hold the data line low forever
			st_d = kpq_pkg::KPQ_IDLE;
			oe_d = 1'b0;
		end else if (scl_s && !scl_p_q) begin
			if (st_q == kpq_pkg::KPQ_ADDR || st_q == kpq_pkg::KPQ_PTR || st_q == kpq_pkg::KPQ_WR) begin
				sh_d = {sh_q[6:0], sda_s};
				bit_d = bit_q + 4'h1;
			end
			if (st_q == kpq_pkg::KPQ_RACK)
				nack_d = sda_s;
		end else if (!scl_s && scl_p_q) begin
			unique case (st_q)
				kpq_pkg::KPQ_IDLE: begin
				end
				kpq_pkg::KPQ_ADDR: begin
					if (bit_q == 4'h8) begin
						if (sh_q[7:1] == DEV_ADDR) begin
							st_d = kpq_pkg::KPQ_AACK;
							oe_d = 1'b1;
							rw_d = sh_q[0];
						end else begin
							st_d = kpq_pkg::KPQ_IDLE;
						end
					end
				end
				kpq_pkg::KPQ_AACK: begin
					oe_d = 1'b0;
					bit_d = 4'h0;
					if (rw_q)
						load = 1'b1;
					else
						st_d = kpq_pkg::KPQ_PTR;
				end
				kpq_pkg::KPQ_PTR: begin
					if (bit_q == 4'h8) begin
						ptr_d = sh_q;
						st_d = kpq_pkg::KPQ_PACK;
						oe_d = 1'b1;
					end
				end
				kpq_pkg::KPQ_PACK, kpq_pkg::KPQ_WACK: begin
					oe_d = 1'b0;
					bit_d = 4'h0;
					st_d = kpq_pkg::KPQ_WR;
				end
				kpq_pkg::KPQ_WR: begin
					if (bit_q == 4'h8) begin
						if (ptr_q == `KPQ_OFS_CONFIG)
							cfg_d = (cfg_q & ~`KPQ_CFG_WMASK) | (sh_q & `KPQ_CFG_WMASK);
						if (!is_event)
							ptr_d = ptr_q + 8'h01;
						st_d = kpq_pkg::KPQ_WACK;
						oe_d = 1'b1;
					end
				end
				kpq_pkg::KPQ_RD: begin
					if (bit_q == 4'h8) begin
						oe_d = 1'b0;
						st_d = kpq_pkg::KPQ_RACK;
					end else begin
						oe_d = ~sh_q[6];
						sh_d = {sh_q[6:0], 1'b0};
						bit_d = bit_q + 4'h1;
					end
				end
				kpq_pkg::KPQ_RACK: begin
					if (nack_q)
						st_d = kpq_pkg::KPQ_IDLE;
					else
						load = 1'b1;
				end
			endcase
		end
		if (load) begin
			sh_d = rd_byte;
			oe_d = ~rd_byte[7];
			bit_d = 4'h1;
			st_d = kpq_pkg::KPQ_RD;
			if (!is_event)
				ptr_d = ptr_q + 8'h01;
		end
		// Autosleep and autowake only move the sleep bit while PWM is off
		if (!cc_pwm_en && autosleep_req)
			cfg_d[`KPQ_BIT_SLEEP] = 1'b0;
		new_ev = (req_s != ack_q);
		press = !hold_q[`KPQ_EV_REL] && !hold_q[`KPQ_ENT_RPT];
		if (new_ev && press && !cc_pwm_en && !cfg_q[`KPQ_BIT_SLEEP] && cfg_q[`KPQ_BIT_WAKEEN])
			cfg_d[`KPQ_BIT_SLEEP] = 1'b1;
		accept = new_ev && (scan_q || cfg_d[`KPQ_BIT_SLEEP]) && (!hold_q[`KPQ_EV_REL] || cfg_q[`KPQ_BIT_RELEN]);
		pop = load && is_event && !ovf_q && cnt_q != '0;
		push = accept && (cnt_q != FULL || pop);
		ack_d = req_s;
		wp_d = push ? wp_q + AW'(1) : wp_q;
		rp_d = pop ? rp_q + AW'(1) : rp_q;
		cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
		// Overflow lost in the same cycle as its report is kept: set beats clear
		ovf_d = (ovf_q && !(load && is_event)) || (accept && !push);
		if (cfg_q[`KPQ_BIT_INTMODE])
			int_n_d = !(push || (!int_n_q && !(load && is_event)));
		else
			int_n_d = (cnt_d == '0) && !ovf_d;
		scan_d = cc_pwm_en || cfg_d[`KPQ_BIT_SLEEP];
		to_en_d = !cfg_d[`KPQ_BIT_TODIS];
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			ovf_q <= 1'b0;
			ack_q <= 1'b0;
			int_n_q <= 1'b1;
			cfg_q <= `KPQ_CFG_RESET & `KPQ_CFG_WMASK;
			scan_q <= 1'b0;
			to_en_q <= 1'b0;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			st_q <= kpq_pkg::KPQ_IDLE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			ptr_q <= 8'h00;
			rw_q <= 1'b0;
			nack_q <= 1'b0;
			oe_q <= 1'b0;
			to_q <= '0;
			sda_o <= 1'b0;
		end else begin
			if (push)
				mem[wp_q] <= hold_q;
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
			ovf_q <= ovf_d;
			ack_q <= ack_d;
			int_n_q <= int_n_d;
			cfg_q <= cfg_d;
			scan_q <= scan_d;
			to_en_q <= to_en_d;
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
			st_q <= st_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			ptr_q <= ptr_d;
			rw_q <= rw_d;
			nack_q <= nack_d;
			oe_q <= oe_d;
			to_q <= to_d;
			sda_o <= 1'b0;
		end
	end
	assign sda_oe = oe_q;
	assign int_n = int_n_q;
	assign scan_active = scan_q;
	assign bus_timeout_en = to_en_q;

	// ==========================================================
	// Assertions
	// ==========================================================
	logic ld_ev;
	assign ld_ev = load && is_event;

	empty_code_a: assert property (@(posedge clk) disable iff (!reset_n)
		ld_ev && !ovf_q && cnt_q == '0 |=> sh_q == {2'b00, `KPQ_KEY_ALL1}) else $error("empty code wrong");
	ovf_code_a: assert property (@(posedge clk) disable iff (!reset_n)
		ld_ev && ovf_q |=> sh_q == {2'b01, `KPQ_KEY_ALL1} && cnt_q == $past(cnt_q) + (AW + 1)'($past(push)))
		else $error("overflow code wrong");
	last_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
		pop && cnt_q == (AW + 1)'(1) && ent[5:0] < `KPQ_KEY_REPEAT |=> !sh_q[`KPQ_EV_MORE])
		else $error("last entry flagged more");
	more_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
		pop && more && !ent[`KPQ_ENT_RPT] |=> sh_q[7]) else $error("more entries not flagged");
	key_high_a: assert property (@(posedge clk) disable iff (!reset_n)
		pop && !ent[`KPQ_ENT_RPT] && ent[5:0] >= `KPQ_KEY_REPEAT |=> sh_q[`KPQ_EV_MORE] && sh_q[5:0] == $past(ent[5:0]))
		else $error("key 62/63 flag");
	rel_key_a: assert property (@(posedge clk) disable iff (!reset_n)
		pop && !ent[`KPQ_ENT_RPT] |=> sh_q[6:0] == $past(ent[6:0])) else $error("key or release bit wrong");
	repeat_code_a: assert property (@(posedge clk) disable iff (!reset_n)
		pop && ent[`KPQ_ENT_RPT] |=> sh_q == {1'b0, $past(more), `KPQ_KEY_REPEAT}) else $error("repeat code wrong");
	int_level_a: assert property (@(posedge clk) disable iff (!reset_n)
		!cfg_q[`KPQ_BIT_INTMODE] && $past(!cfg_q[`KPQ_BIT_INTMODE]) |-> int_n == (cnt_q == '0 && !ovf_q)) else $error("int level");
	int_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
		cfg_q[`KPQ_BIT_INTMODE] && push |=> !int_n) else $error("int not set");
	cc_active_a: assert property (@(posedge clk) disable iff (!reset_n)
		cc_pwm_en |=> scan_active) else $error("scan stopped under PWM");
	sleep_off_a: assert property (@(posedge clk) disable iff (!reset_n)
		!cc_pwm_en && !cfg_d[`KPQ_BIT_SLEEP] |=> !scan_active) else $error("shutdown ignored");
	sleep_read_a: assert property (@(posedge clk) disable iff (!reset_n)
		load && ptr_q == `KPQ_OFS_CONFIG |=> sh_q[7] == $past(cfg_q[`KPQ_BIT_SLEEP])) else $error("sleep not readable");
	rel_drop_a: assert property (@(posedge clk) disable iff (!reset_n)
		new_ev && hold_q[`KPQ_EV_REL] && !cfg_q[`KPQ_BIT_RELEN] |-> !push) else $error("release queued");
	wake_a: assert property (@(posedge clk) disable iff (!reset_n)
		new_ev && press && !cc_pwm_en && !cfg_q[`KPQ_BIT_SLEEP] && cfg_q[`KPQ_BIT_WAKEEN] && !autosleep_req
		|=> cfg_q[`KPQ_BIT_SLEEP]) else $error("no wake");

	ovf_seen_c: cover property (@(posedge clk) disable iff (!reset_n) ld_ev && ovf_q);
	key63_c: cover property (@(posedge clk) disable iff (!reset_n) pop && ent[5:0] == 6'h3f);
	wake_c: cover property (@(posedge clk) disable iff (!reset_n) !cfg_q[`KPQ_BIT_SLEEP] ##1 cfg_q[`KPQ_BIT_SLEEP]);
	full_c: cover property (@(posedge clk) disable iff (!reset_n) cnt_q == FULL);
endmodule : kpq_top

// ### rtl/kpq_regs.svh
// Register offsets, field positions, codes and timing constants of the key event queue.
// Assumes inclusion by bare name from the rtl/ folder; definitions only.
//
// Contract
// - Each event read returns one queued event, key index in bits 5:0.
// - Bit 7 low on the last queued entry, high while more remain.
// - Bit 6 set for a key release, clear for a key press.
// - Events of keys 62 and 63 always return bit 7 set.
// - Bit 7 clear, key all ones: bit 6 clear empty, set overflow.
// - Bit 7 clear, key 62 code: autorepeat; bit 6 tells more entries.
// - Constant-current PWM enabled keeps key scanning active regardless of sleep.
// - PWM disabled: writes, autosleep, autowake change sleep bit; always readable.
// - Interrupt mode 0 holds interrupt until the queue is empty.
`ifndef KPQ_REGS_SVH
`define KPQ_REGS_SVH

`define KPQ_OFS_EVENT 8'h00
`define KPQ_OFS_CONFIG 8'h01
`define KPQ_CFG_RESET 8'h09
`define KPQ_CFG_WMASK 8'hab
`define KPQ_BIT_SLEEP 7
`define KPQ_BIT_INTMODE 5
`define KPQ_BIT_RELEN 3
`define KPQ_BIT_WAKEEN 1
`define KPQ_BIT_TODIS 0
`define KPQ_EV_MORE 7
`define KPQ_EV_REL 6
`define KPQ_ENT_RPT 7
`define KPQ_KEY_ALL1 6'h3f
`define KPQ_KEY_REPEAT 6'h3e
`define KPQ_QUEUE_DEPTH 16
// Bus address value is arbitrary
`define KPQ_DEV_ADDR 7'h38
`define KPQ_TIMEOUT_MS 25
`define KPQ_CLK_KHZ 100000

`endif

// ### rtl/kpq_pkg.sv
// Types shared by the key event queue design.
// Assumes nothing of its surroundings.
package kpq_pkg;
	typedef enum logic [3:0] {
		KPQ_IDLE, KPQ_ADDR, KPQ_AACK, KPQ_PTR, KPQ_PACK, KPQ_WR, KPQ_WACK, KPQ_RD, KPQ_RACK
	} kpq_bus_state_type;
endpackage : kpq_pkg

// ### rtl/kpq_sync.sv
// Two-flop synchroniser for levels entering a clock domain.
// Assumes each bit is an independent level or a toggle; INIT is each bit's idle level.
`timescale 1ns/10ps
module kpq_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			meta_q <= INIT;
			q <= INIT;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : kpq_sync

// ### tb/kpq_host.sv
// Two-wire bus master standing in for the host controller.
// Assumes SDA is resolved with a pull-up outside; clk paces every bus phase.
`timescale 1ns/10ps
module kpq_host #(
	parameter logic [6:0] ADDR = 7'h38
) (
	input wire logic clk,
	input wire logic sda,
	output logic scl = 1'b1,
	output logic sda_oe = 1'b0
);
	// ==========================================
	// Bus phases; SCL stays high and low for at least four clk each
	task automatic ph(input logic s, input logic d, input int n);
		scl = s;
		sda_oe = d;
		repeat (n) @(posedge clk);
		#1;
	endtask : ph
	// SDA is released while SCL is still low, so this also gives a repeated start
	task automatic start();
		ph(scl, 1'b0, 4);
		ph(1'b1, 1'b0, 8);
		ph(1'b1, 1'b1, 8);
		ph(1'b0, 1'b1, 2);
	endtask : start
	task automatic stop();
		ph(1'b0, 1'b1, 6);
		ph(1'b1, 1'b1, 8);
		ph(1'b1, 1'b0, 8);
	endtask : stop
	// Nine bits MSB first, the last being the acknowledge slot
	task automatic xfer(input logic [8:0] d, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			ph(1'b0, ~d[i], 6);
			ph(1'b1, ~d[i], 4);
			r[i] = sda;
			ph(1'b1, ~d[i], 4);
			ph(1'b0, ~d[i], 2);
		end
	endtask : xfer
	// A read always ends with a NACK, so only one byte is taken
	task automatic access(input logic [7:0] ptr, input logic rd, input logic [7:0] wd, output logic [7:0] q);
		logic [8:0] r;
		start();
		xfer({ADDR, 1'b0, 1'b1}, r);
		xfer({ptr, 1'b1}, r);
		if (rd) begin
			start();
			xfer({ADDR, 1'b1, 1'b1}, r);
		end
		xfer({rd ? 8'hff : wd, 1'b1}, r);
		q = r[8:1];
		stop();
	endtask : access
endmodule : kpq_host

// ### tb/keypad_event_fifo_config_tb.sv
// Self-checking bench for the key event queue and the configuration register.
// Assumes rtl/ on the include path and kpq_host as the only bus master.
`timescale 1ns/10ps
`include "kpq_regs.svh"
module keypad_event_fifo_config_tb;
	// ==========================================
	// Wiring
	logic clk = 1'b0, scan_clk = 1'b0, reset_n = 1'b0, scan_reset_n = 1'b0, cc_pwm_en = 1'b0;
	logic autosleep_req = 1'b0, ev_valid = 1'b0, ev_release = 1'b0, ev_repeat = 1'b0;
	logic [5:0] ev_key = 6'h00;
	logic scl, host_oe, sda_o, sda_oe, int_n, scan_active, bus_timeout_en, ev_ready;
	logic [7:0] rv;
	logic [8:0] hr;
	logic [31:0] seed = 32'heb4f;
	logic [5:0] kq[$];
	logic rq[$];
	int errors = 0, tests_run = 0, cyc = 0;
	wire logic sda = ~(sda_oe | host_oe);
	always #5 clk = ~clk;
	always #7.5 scan_clk = ~scan_clk;
	kpq_top #(.TIMEOUT_CYCLES(200)) dut_u (.clk(clk), .reset_n(reset_n), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .int_n(int_n), .cc_pwm_en(cc_pwm_en), .autosleep_req(autosleep_req),
		.scan_active(scan_active), .bus_timeout_en(bus_timeout_en), .scan_clk(scan_clk),
		.scan_reset_n(scan_reset_n), .ev_valid(ev_valid), .ev_key(ev_key), .ev_release(ev_release),
		.ev_repeat(ev_repeat), .ev_ready(ev_ready));
	kpq_host #(.ADDR(`KPQ_DEV_ADDR)) host_u (.clk(clk), .sda(sda), .scl(scl), .sda_oe(host_oe));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	function automatic logic [7:0] exp_ev(input logic [5:0] k, input logic rel, input logic more);
		if (k >= 6'd62)
			return {1'b1, rel, k};
		return {more, rel, k};
	endfunction : exp_ev
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		host_u.access(p, 1'b0, d, rv);
	endtask : wr
	task automatic rc(input logic [7:0] p, input logic [7:0] e);
		host_u.access(p, 1'b1, 8'h00, rv);
		chk(p == 8'h00 ? "event" : "register", e, rv);
	endtask : rc
	task automatic push(input logic [5:0] k, input logic rel, input logic rpt);
		int n = 0;
		@(posedge scan_clk);
		#1;
		{ev_valid, ev_key, ev_release, ev_repeat} = {1'b1, k, rel, rpt};
		do begin
			@(posedge scan_clk);
			n++;
		end while (ev_ready !== 1'b1 && n < 50);
		// Looked at on the taking edge, before the handshake drops ready
		chk("ev_ready", 8'h01, {7'h00, ev_ready});
		#1;
		ev_valid = 1'b0;
		repeat (12) @(posedge clk);
		#1;
	endtask : push
	task automatic rpush(input int n);
		kq.delete();
		rq.delete();
		for (int i = 0; i < n; i++) begin
			seed = xs(seed);
			kq.push_back(6'(seed[5:0] % 6'd62));
			rq.push_back(seed[8]);
			push(kq[i], rq[i], 1'b0);
		end
	endtask : rpush
	task automatic drain(input int n);
		for (int i = 0; i < n; i++)
			rc(8'h00, exp_ev(kq[i], rq[i], i < n - 1));
	endtask : drain
	task automatic tally_and_finish();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : tally_and_finish
	// ==========================================
	// Scenarios
	initial begin
		repeat (20) @(posedge clk);
		#1;
		{reset_n, scan_reset_n} = 2'b11;
		repeat (6) @(posedge clk);
		#1;
		chk("int_n", 8'h01, {7'h00, int_n});
		chk("scan_active", 8'h00, {7'h00, scan_active});
		chk("bus_timeout_en", 8'h00, {7'h00, bus_timeout_en});
		chk("sda_o", 8'h00, {7'h00, sda_o});
		rc(8'h01, 8'h09);
		rc(8'h00, 8'h3f);
		wr(8'h01, 8'hff);
		rc(8'h01, 8'hab);
		chk("scan_active", 8'h01, {7'h00, scan_active});
		wr(8'h00, 8'h55);
		rc(8'h05, 8'h00);
		wr(8'h01, 8'h88);
		chk("bus_timeout_en", 8'h01, {7'h00, bus_timeout_en});
		rpush(4);
		chk("int_n", 8'h00, {7'h00, int_n});
		drain(4);
		chk("int_n", 8'h01, {7'h00, int_n});
		for (int k = 62; k < 64; k++) begin
			push(6'(k), k[0], 1'b0);
			push(6'h05, 1'b0, 1'b0);
			rc(8'h00, {1'b1, k[0], 6'(k)});
			rc(8'h00, 8'h05);
			rc(8'h00, 8'h3f);
		end
		repeat (2) push(6'h00, 1'b0, 1'b1);
		rc(8'h00, 8'h7e);
		rc(8'h00, 8'h3e);
		rpush(17);
		rc(8'h00, 8'h7f);
		drain(16);
		wr(8'h01, 8'h80);
		push(6'h07, 1'b1, 1'b0);
		push(6'h07, 1'b0, 1'b0);
		rc(8'h00, 8'h07);
		wr(8'h01, 8'ha8);
		rpush(2);
		chk("int_n", 8'h00, {7'h00, int_n});
		rc(8'h00, exp_ev(kq[0], rq[0], 1'b1));
		chk("int_n", 8'h01, {7'h00, int_n});
		rc(8'h00, exp_ev(kq[1], rq[1], 1'b0));
		wr(8'h01, 8'h09);
		chk("scan_active", 8'h00, {7'h00, scan_active});
		push(6'h09, 1'b0, 1'b0);
		rc(8'h00, 8'h3f);
		cc_pwm_en = 1'b1;
		push(6'h09, 1'b0, 1'b0);
		chk("scan_active", 8'h01, {7'h00, scan_active});
		rc(8'h00, 8'h09);
		cc_pwm_en = 1'b0;
		wr(8'h01, 8'h8b);
		autosleep_req = 1'b1;
		@(posedge clk);
		#1;
		autosleep_req = 1'b0;
		rc(8'h01, 8'h0b);
		chk("scan_active", 8'h00, {7'h00, scan_active});
		push(6'h04, 1'b0, 1'b0);
		rc(8'h01, 8'h8b);
		rc(8'h00, 8'h04);
		// Timeout on: a read stalled with SCL low must let go of SDA
		wr(8'h01, 8'h08);
		chk("bus_timeout_en", 8'h01, {7'h00, bus_timeout_en});
		host_u.start();
		host_u.xfer({`KPQ_DEV_ADDR, 1'b0, 1'b1}, hr);
		host_u.xfer({`KPQ_OFS_CONFIG, 1'b1}, hr);
		host_u.start();
		host_u.xfer({`KPQ_DEV_ADDR, 1'b1, 1'b1}, hr);
		repeat (8) @(posedge clk);
		#1;
		chk("sda_oe", 8'h01, {7'h00, sda_oe});
		repeat (250) @(posedge clk);
		#1;
		chk("sda_oe", 8'h00, {7'h00, sda_oe});
		host_u.stop();
		tally_and_finish();
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			errors++;
			tally_and_finish();
		end
	end
endmodule : keypad_event_fifo_config_tb
